// >>> hw/flat_and_export_format_decoder.v
// field decoder for the flat memory format and the export format
`include "flat_export_consts.vh"
`default_nettype none

module flat_and_export_format_decoder (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // instruction from issue
    input wire instr_valid_in,
    input wire export_format_in,
    input wire [63:0] instr_word_in,
    input wire [1:0] export_target_class_in,
    input wire pixel_shader_in,
    // common
    output wire decoded_valid_out,
    output wire export_decoded_out,
    // flat memory controls
    output wire [1:0] segment_select_out,
    output wire segment_flat_out,
    output wire segment_scratch_out,
    output wire segment_global_out,
    output wire segment_illegal_out,
    output wire any_aperture_out,
    output wire [31:0] offset_out,
    output wire local_share_transfer_out,
    output wire coherent_bypass_out,
    output wire [7:0] addr_low_register_out,
    output wire [7:0] addr_high_register_out,
    output wire addr_is_64bit_out,
    output wire addr_is_offset32_out,
    output wire addr_uses_vector_out,
    output wire [6:0] scalar_base_select_out,
    output wire scalar_enable_out,
    output wire scalar_is_address_out,
    output wire scalar_plus_vector_out,
    output wire [7:0] data_register_out,
    output wire [7:0] return_register_select_out,
    // export controls
    output wire packed_export_out,
    output wire [3:0] source_enable_out,
    output wire enable_illegal_out,
    output wire null_export_out,
    output wire export_done_out,
    output wire valid_mask_flag_out,
    output wire [7:0] export_source_zero_out,
    output wire [7:0] export_source_one_out,
    output wire [7:0] export_source_two_out,
    output wire [7:0] export_source_three_out
);

////////////////////////////////////////////////////////////////////////////////
// field slices of the incoming word

wire [1:0] segment_field = instr_word_in[`SEGMENT_HI:`SEGMENT_LO];
wire [12:0] ofs_field = instr_word_in[`OFS_HI:`OFS_LO];
wire [6:0] scalar_field = instr_word_in[`SCALAR_HI:`SCALAR_LO];
wire [7:0] addr_field = instr_word_in[`ADDR_HI:`ADDR_LO];
wire [3:0] en_field = instr_word_in[`EN_HI:`EN_LO];
wire packed_bit = instr_word_in[`PACKED_BIT];
wire is_flat = (segment_field == `SEGMENT_FLAT);
wire is_scratch = (segment_field == `SEGMENT_SCRATCH);
wire is_global = (segment_field == `SEGMENT_GLOBAL);
// flat ignores the scalar field whatever it holds
wire scalar_on = ~is_flat & (scalar_field != `SCALAR_OFF);

////////////////////////////////////////////////////////////////////////////////
// registers and next values

reg valid_reg;
reg valid_next;
reg export_reg;
reg export_next;
reg [1:0] segment_reg;
reg [1:0] segment_next;
reg flat_reg;
reg flat_next;
reg scratch_reg;
reg scratch_next;
reg global_reg;
reg global_next;
reg segment_bad_reg;
reg segment_bad_next;
reg any_ap_reg;
reg any_ap_next;
reg [31:0] ofs_reg;
reg [31:0] ofs_next;
reg share_reg;
reg share_next;
reg coherent_reg;
reg coherent_next;
reg [7:0] addr_lo_reg;
reg [7:0] addr_lo_next;
reg [7:0] addr_hi_reg;
reg [7:0] addr_hi_next;
reg addr64_reg;
reg addr64_next;
reg addr_ofs_reg;
reg addr_ofs_next;
reg addr_vec_reg;
reg addr_vec_next;
reg [6:0] scalar_sel_reg;
reg [6:0] scalar_sel_next;
reg scalar_en_reg;
reg scalar_en_next;
reg scalar_addr_reg;
reg scalar_addr_next;
reg scalar_sum_reg;
reg scalar_sum_next;
reg [7:0] data_reg;
reg [7:0] data_next;
reg [7:0] ret_reg;
reg [7:0] ret_next;
reg packed_reg;
reg packed_next;
reg [3:0] src_en_reg;
reg [3:0] src_en_next;
reg en_bad_reg;
reg en_bad_next;
reg null_reg;
reg null_next;
reg done_reg;
reg done_next;
reg mask_reg;
reg mask_next;
reg [7:0] src0_reg;
reg [7:0] src0_next;
reg [7:0] src1_reg;
reg [7:0] src1_next;
reg [7:0] src2_reg;
reg [7:0] src2_next;
reg [7:0] src3_reg;
reg [7:0] src3_next;

////////////////////////////////////////////////////////////////////////////////
// decode

// fields of the format not in use are forced to their reset values so that
// a consumer never sees stale controls from the other format
always @* begin
    valid_next = instr_valid_in;
    export_next = instr_valid_in & export_format_in;
    segment_next = 2'h0;
    flat_next = 1'b0;
    scratch_next = 1'b0;
    global_next = 1'b0;
    segment_bad_next = 1'b0;
    any_ap_next = 1'b0;
    ofs_next = `RST_OFS;
    share_next = 1'b0;
    coherent_next = 1'b0;
    addr_lo_next = `RST_REG8;
    addr_hi_next = `RST_REG8;
    addr64_next = 1'b0;
    addr_ofs_next = 1'b0;
    addr_vec_next = 1'b0;
    scalar_sel_next = `RST_SCALAR;
    scalar_en_next = 1'b0;
    scalar_addr_next = 1'b0;
    scalar_sum_next = 1'b0;
    data_next = `RST_REG8;
    ret_next = `RST_REG8;
    packed_next = 1'b0;
    src_en_next = 4'h0;
    en_bad_next = 1'b0;
    null_next = 1'b0;
    done_next = 1'b0;
    mask_next = 1'b0;
    src0_next = `RST_REG8;
    src1_next = `RST_REG8;
    src2_next = `RST_REG8;
    src3_next = `RST_REG8;
    if (instr_valid_in && !export_format_in) begin
        // one layout for all three variants, segment alone tells them apart
        segment_next = segment_field;
        flat_next = is_flat;
        scratch_next = is_scratch;
        global_next = is_global;
        segment_bad_next = ~(is_flat | is_scratch | is_global);
        // flat leaves aperture choice per lane to the memory pipe
        any_ap_next = is_flat;
        if (is_flat) begin
            ofs_next = {20'h00000, ofs_field[`OFS_FLAT_HI:0]};
        end else begin
            ofs_next = {{19{ofs_field[12]}}, ofs_field};
        end
        share_next = instr_word_in[`SHARE_BIT];
        coherent_next = instr_word_in[`COHERENT_BIT];
        addr_lo_next = addr_field;
        addr_hi_next = addr_field + 8'h01;
        scalar_sel_next = scalar_field;
        scalar_en_next = scalar_on;
        // scratch with scalar on needs no vector register at all
        scalar_addr_next = is_scratch & scalar_on;
        scalar_sum_next = is_global & scalar_on;
        addr_ofs_next = scalar_on & is_global;
        addr64_next = ~scalar_on;
        addr_vec_next = ~(is_scratch & scalar_on);
        data_next = instr_word_in[`DATA_HI:`DATA_LO];
        ret_next = instr_word_in[`RETURN_HI:`RETURN_LO];
    end
    if (instr_valid_in && export_format_in) begin
        // single operation: no opcode bits are looked at
        packed_next = packed_bit;
        if (packed_bit) begin
            src_en_next = {2'b00, en_field[2], en_field[0]};
            en_bad_next = (en_field != `EN_NONE) && (en_field != `EN_LOW) &&
                          (en_field != `EN_HIGH) && (en_field != `EN_ALL);
        end else begin
            src_en_next = en_field;
        end
        // an empty enable is legal only for a null pixel export; null_export_out is set for any empty enable whatever pixel_shader_in holds
        null_next = (en_field == `EN_NONE);
        done_next = instr_word_in[`DONE_BIT] &
                    ((export_target_class_in == `TGT_POSITION) |
                     (export_target_class_in == `TGT_COLOR));
        mask_next = instr_word_in[`MASK_BIT] & pixel_shader_in;
        src0_next = instr_word_in[`SRC0_HI:`SRC0_LO];
        src1_next = instr_word_in[`SRC1_HI:`SRC1_LO];
        src2_next = instr_word_in[`SRC2_HI:`SRC2_LO];
        src3_next = instr_word_in[`SRC3_HI:`SRC3_LO];
    end
end

////////////////////////////////////////////////////////////////////////////////
// output flops

always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        valid_reg <= 1'b0;
        export_reg <= 1'b0;
        segment_reg <= 2'h0;
        flat_reg <= 1'b0;
        scratch_reg <= 1'b0;
        global_reg <= 1'b0;
        segment_bad_reg <= 1'b0;
        any_ap_reg <= 1'b0;
        ofs_reg <= `RST_OFS;
        share_reg <= 1'b0;
        coherent_reg <= 1'b0;
        addr_lo_reg <= `RST_REG8;
        addr_hi_reg <= `RST_REG8;
        addr64_reg <= 1'b0;
        addr_ofs_reg <= 1'b0;
        addr_vec_reg <= 1'b0;
        scalar_sel_reg <= `RST_SCALAR;
        scalar_en_reg <= 1'b0;
        scalar_addr_reg <= 1'b0;
        scalar_sum_reg <= 1'b0;
        data_reg <= `RST_REG8;
        ret_reg <= `RST_REG8;
        packed_reg <= 1'b0;
        src_en_reg <= 4'h0;
        en_bad_reg <= 1'b0;
        null_reg <= 1'b0;
        done_reg <= 1'b0;
        mask_reg <= 1'b0;
        src0_reg <= `RST_REG8;
        src1_reg <= `RST_REG8;
        src2_reg <= `RST_REG8;
        src3_reg <= `RST_REG8;
    end else begin
        valid_reg <= valid_next;
        export_reg <= export_next;
        segment_reg <= segment_next;
        flat_reg <= flat_next;
        scratch_reg <= scratch_next;
        global_reg <= global_next;
        segment_bad_reg <= segment_bad_next;
        any_ap_reg <= any_ap_next;
        ofs_reg <= ofs_next;
        share_reg <= share_next;
        coherent_reg <= coherent_next;
        addr_lo_reg <= addr_lo_next;
        addr_hi_reg <= addr_hi_next;
        addr64_reg <= addr64_next;
        addr_ofs_reg <= addr_ofs_next;
        addr_vec_reg <= addr_vec_next;
        scalar_sel_reg <= scalar_sel_next;
        scalar_en_reg <= scalar_en_next;
        scalar_addr_reg <= scalar_addr_next;
        scalar_sum_reg <= scalar_sum_next;
        data_reg <= data_next;
        ret_reg <= ret_next;
        packed_reg <= packed_next;
        src_en_reg <= src_en_next;
        en_bad_reg <= en_bad_next;
        null_reg <= null_next;
        done_reg <= done_next;
        mask_reg <= mask_next;
        src0_reg <= src0_next;
        src1_reg <= src1_next;
        src2_reg <= src2_next;
        src3_reg <= src3_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign decoded_valid_out = valid_reg;
assign export_decoded_out = export_reg;
assign segment_select_out = segment_reg;
assign segment_flat_out = flat_reg;
assign segment_scratch_out = scratch_reg;
assign segment_global_out = global_reg;
assign segment_illegal_out = segment_bad_reg;
assign any_aperture_out = any_ap_reg;
assign offset_out = ofs_reg;
assign local_share_transfer_out = share_reg;
assign coherent_bypass_out = coherent_reg;
assign addr_low_register_out = addr_lo_reg;
assign addr_high_register_out = addr_hi_reg;
assign addr_is_64bit_out = addr64_reg;
assign addr_is_offset32_out = addr_ofs_reg;
assign addr_uses_vector_out = addr_vec_reg;
assign scalar_base_select_out = scalar_sel_reg;
assign scalar_enable_out = scalar_en_reg;
assign scalar_is_address_out = scalar_addr_reg;
assign scalar_plus_vector_out = scalar_sum_reg;
assign data_register_out = data_reg;
assign return_register_select_out = ret_reg;
assign packed_export_out = packed_reg;
assign source_enable_out = src_en_reg;
assign enable_illegal_out = en_bad_reg;
assign null_export_out = null_reg;
assign export_done_out = done_reg;
assign valid_mask_flag_out = mask_reg;
assign export_source_zero_out = src0_reg;
assign export_source_one_out = src1_reg;
assign export_source_two_out = src2_reg;
assign export_source_three_out = src3_reg;

endmodule

`default_nettype wire

// >>> include/flat_export_consts.vh
// field positions, codes and reset values for the flat and export word decoder
`ifndef FLAT_EXPORT_CONSTS_VH
`define FLAT_EXPORT_CONSTS_VH

// flat-format fields
`define OFS_HI 12
`define OFS_LO 0
`define OFS_FLAT_HI 11
`define SHARE_BIT 13
`define SEGMENT_HI 15
`define SEGMENT_LO 14
`define COHERENT_BIT 16
`define ADDR_HI 39
`define ADDR_LO 32
`define DATA_HI 47
`define DATA_LO 40
`define SCALAR_HI 54
`define SCALAR_LO 48
`define RETURN_HI 63
`define RETURN_LO 56

// segment codes
`define SEGMENT_FLAT 2'h0
`define SEGMENT_SCRATCH 2'h1
`define SEGMENT_GLOBAL 2'h2

// scalar field value that turns scalar addressing off
`define SCALAR_OFF 7'h7f

// export-format fields
`define EN_HI 3
`define EN_LO 0
`define PACKED_BIT 10
`define DONE_BIT 11
`define MASK_BIT 12
`define SRC0_HI 39
`define SRC0_LO 32
`define SRC1_HI 47
`define SRC1_LO 40
`define SRC2_HI 55
`define SRC2_LO 48
`define SRC3_HI 63
`define SRC3_LO 56

// legal packed enable values
`define EN_NONE 4'h0
`define EN_LOW 4'h3
`define EN_HIGH 4'hc
`define EN_ALL 4'hf

// export target classes
`define TGT_OTHER 2'h0
`define TGT_POSITION 2'h1
`define TGT_COLOR 2'h2

// reset values
`define RST_REG8 8'h00
`define RST_OFS 32'h0000_0000
`define RST_SCALAR 7'h7f

`endif

// >>> sim/dec_check_asserts.sv
// concurrent checks on the ports of the flat and export word decoder
`default_nettype none
module dec_check (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // issue side
    input wire logic instr_valid_in,
    input wire logic export_format_in,
    input wire logic [63:0] instr_word_in,
    // decoded fields
    input wire logic segment_scratch_out,
    input wire logic [31:0] offset_out,
    input wire logic local_share_transfer_out,
    input wire logic coherent_bypass_out,
    input wire logic [7:0] addr_low_register_out,
    input wire logic [7:0] addr_high_register_out,
    input wire logic addr_is_64bit_out,
    input wire logic scalar_is_address_out,
    input wire logic scalar_plus_vector_out,
    input wire logic [7:0] return_register_select_out,
    input wire logic [3:0] source_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] w_q;
    wire [1:0] kd = instr_word_in[15:14];
    wire sc_on = instr_word_in[54:48] != 7'h7f;
    ////////////////////////////////////////
    // word copy lets the field-value checks compare against the taken word
    always @(posedge clk_in) w_q <= instr_word_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence mem_take;
        instr_valid_in && !export_format_in;
    endsequence
    sequence export_take;
        instr_valid_in && export_format_in;
    endsequence
    a_scratch_kind: assert property (
        mem_take ##0 kd == 2'h1 |=> segment_scratch_out) else $error("scratch kind not flagged");
    a_flat_offset: assert property (
        mem_take ##0 kd == 2'h0 |=> offset_out == {20'h0, w_q[11:0]}) else $error("flat offset wrong");
    a_signed_offset: assert property (
        mem_take ##0 kd[0] ^ kd[1] |=> offset_out == {{19{w_q[12]}}, w_q[12:0]}) else $error("signed offset wrong");
    a_share_coherent: assert property (
        mem_take |=> local_share_transfer_out == w_q[13] && coherent_bypass_out == w_q[16])
        else $error("share or coherence bit wrong");
    a_addr_pair: assert property (
        mem_take |=> addr_low_register_out == w_q[39:32] && addr_high_register_out == w_q[39:32] + 8'h1)
        else $error("address register pair wrong");
    a_scalar_off: assert property (
        mem_take ##0 (kd == 2'h0 || !sc_on) |=> addr_is_64bit_out) else $error("scalar not disabled");
    a_scratch_scalar: assert property (
        mem_take ##0 kd == 2'h1 && sc_on |=> scalar_is_address_out && !addr_is_64bit_out)
        else $error("scratch scalar address wrong");
    a_global_scalar: assert property (
        mem_take ##0 kd == 2'h2 && sc_on |=> scalar_plus_vector_out) else $error("global base wrong");
    a_return_sel: assert property (
        mem_take |=> return_register_select_out == w_q[63:56]) else $error("return register wrong");
    a_packed_en: assert property (
        export_take ##0 instr_word_in[10] |=> source_enable_out == {2'h0, w_q[2], w_q[0]})
        else $error("packed enables wrong");
    a_unpacked_en: assert property (
        export_take ##0 !instr_word_in[10] |=> source_enable_out == w_q[3:0]) else $error("enables wrong");
endmodule
bind flat_and_export_format_decoder dec_check u_check (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .instr_valid_in(instr_valid_in), .export_format_in(export_format_in), .instr_word_in(instr_word_in),
    .segment_scratch_out(segment_scratch_out), .offset_out(offset_out), .coherent_bypass_out(coherent_bypass_out),
    .local_share_transfer_out(local_share_transfer_out), .addr_low_register_out(addr_low_register_out),
    .addr_high_register_out(addr_high_register_out), .addr_is_64bit_out(addr_is_64bit_out),
    .scalar_is_address_out(scalar_is_address_out), .scalar_plus_vector_out(scalar_plus_vector_out),
    .return_register_select_out(return_register_select_out), .source_enable_out(source_enable_out));
`default_nettype wire

// >>> sim/issue_model.sv
// issue side model that hands instruction words to the decoder
`default_nettype none
module issue_model (
    // clock
    input wire logic clk_in,
    // word to decode
    output logic valid_out,
    output logic format_out,
    output logic pixel_out,
    output logic [1:0] class_out,
    output logic [63:0] word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mask_sent = 1'b0;
    initial {valid_out, format_out, pixel_out, class_out, word_out} = '0;
    ////////////////////////////////////////
    // bad lets a scenario push a packed enable outside the legal set
    task automatic drive(input logic v, f, p, bad, input logic [1:0] c, inout logic [63:0] w);
        @(posedge clk_in);
        if (f && w[10] && !bad) w[3:0] = {w[2], w[2], w[0], w[0]};
        if (f && w[3:0] == 4'h0 && !p) w[3:0] = 4'h3;
        if (v && f && p && !mask_sent) w[12] = 1'b1;
        mask_sent = mask_sent | (v && f && p && w[12]);
        {valid_out, format_out, pixel_out, class_out, word_out} <= {v, f, p, c, w};
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the flat and export word decoder
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    wire instr_valid_in, export_format_in, pixel_shader_in;
    wire [63:0] instr_word_in;
    wire [1:0] export_target_class_in, segment_select_out;
    wire decoded_valid_out, export_decoded_out, segment_flat_out, segment_scratch_out, segment_global_out;
    wire segment_illegal_out, any_aperture_out, local_share_transfer_out, coherent_bypass_out;
    wire addr_is_64bit_out, addr_is_offset32_out, addr_uses_vector_out, scalar_enable_out;
    wire scalar_is_address_out, scalar_plus_vector_out, packed_export_out, enable_illegal_out;
    wire null_export_out, export_done_out, valid_mask_flag_out;
    wire [31:0] offset_out;
    wire [6:0] scalar_base_select_out;
    wire [3:0] source_enable_out;
    wire [7:0] addr_low_register_out, addr_high_register_out, data_register_out, return_register_select_out;
    wire [7:0] export_source_zero_out, export_source_one_out, export_source_two_out, export_source_three_out;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] rnd = 32'h0001_21f5;
    logic [63:0] pw = '0;
    logic [63:0] nw;
    logic pv = 1'b0;
    logic pf, pp, nv, nf, np, bad;
    logic [1:0] pc, nc;
    always #5 clk_in = ~clk_in;
    flat_and_export_format_decoder DUT (.*);
    issue_model iss (.clk_in(clk_in), .valid_out(instr_valid_in), .format_out(export_format_in),
        .pixel_out(pixel_shader_in), .class_out(export_target_class_in), .word_out(instr_word_in));
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task chk(input logic [31:0] s, w);
        n_compared++;
        if (s !== w) begin
            num_errors++;
            $display("ERROR t=%0t seen %h want %h", $time, s, w);
        end
    endtask
    task final_report;
        $display("mismatches %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // reference decode of the word taken at the last edge
    task model;
        int kd;
        int sen;
        int ofs;
        chk({decoded_valid_out, export_decoded_out}, {pv, pv && pf});
        if (!pv) begin
            chk({export_decoded_out, scalar_base_select_out}, {1'b0, 7'h7f});
            chk(offset_out, 0);
        end else if (!pf) begin
            kd = pw[15:14];
            sen = kd != 0 && pw[54:48] != 7'h7f;
            ofs = kd == 0 ? pw[11:0] : {{19{pw[12]}}, pw[12:0]};
            chk(segment_select_out, kd);
            chk({segment_flat_out, segment_scratch_out, segment_global_out, segment_illegal_out},
                {kd == 0, kd == 1, kd == 2, kd == 3});
            chk(any_aperture_out, kd == 0);
            chk(offset_out, ofs);
            chk({local_share_transfer_out, coherent_bypass_out}, {pw[13], pw[16]});
            chk({addr_high_register_out, addr_low_register_out}, {pw[39:32] + 8'h1, pw[39:32]});
            chk({addr_is_offset32_out, addr_uses_vector_out}, {kd == 2 && sen, !(kd == 1 && sen)});
            chk({scalar_enable_out, addr_is_64bit_out, scalar_base_select_out}, {sen != 0, sen == 0, pw[54:48]});
            chk({scalar_is_address_out, scalar_plus_vector_out}, {kd == 1 && sen, kd == 2 && sen});
            chk({data_register_out, return_register_select_out}, {pw[47:40], pw[63:56]});
        end else begin
            chk({packed_export_out, source_enable_out},
                {pw[10], pw[10] ? {2'h0, pw[2], pw[0]} : pw[3:0]});
            chk(enable_illegal_out, pw[10] && !(pw[3:0] inside {4'h0, 4'h3, 4'hc, 4'hf}));
            chk(null_export_out, pw[3:0] == 4'h0);
            chk(export_done_out, pw[11] && (pc == 2'h1 || pc == 2'h2));
            chk(valid_mask_flag_out, pw[12] && pp);
            chk({export_source_three_out, export_source_two_out,
                export_source_one_out, export_source_zero_out}, pw[63:32]);
            chk(segment_select_out, 0);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 800; i++) begin
            rnd = xs(rnd);
            nw[31:0] = rnd;
            rnd = xs(rnd);
            nw[63:32] = rnd;
            rnd = xs(rnd);
            {bad, nc, np, nf} = {rnd[9:6] == 4'h0, rnd[5:2]};
            nv = rnd[0] | rnd[1];
            if (rnd[10]) nw[54:48] = 7'h7f;
            // a second reset in mid-run, with a word still waiting on the inputs
            if (i == 400) begin
                @(negedge clk_in);
                rst_n_in = 1'b0;
                #1;
                chk({decoded_valid_out, scalar_base_select_out}, {1'b0, 7'h7f});
                @(posedge clk_in);
                rst_n_in <= 1'b1;
            end
            iss.drive(nv, nf, np, bad, nc, nw);
            #1;
            model;
            {pv, pf, pp, pc, pw} = {nv, nf, np, nc, nw};
        end
        final_report;
    end
    initial begin
        #100000;
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
